// ==== hw/pfn_regs.svh ====
`ifndef PFN_REGS_SVH
`define PFN_REGS_SVH

`define VEC_LEVEL1 8'h00
`define VEC_LEVEL2 8'h02
`define VEC_TMR0 8'h04
`define VEC_TMR1 8'h06
`define VEC_DMA0 8'h08
`define VEC_DMA1 8'h0A
`define VEC_CSU 8'h0C
`define VEC_SER0 8'h0E
`define VEC_SER1 8'h10
`define VEC_STEP 8'h02
`define NMI_JUMP_ADDR 16'h0066
`define PF_STATUS_BIT 3
`define PC_BYTES 16'h0002
`define CLK_PERIOD_NS 10
`define NMI_LATENCY_NS 100000

`define SRC_TRAP 4'h0
`define SRC_NMI 4'h1
`define SRC_LEVEL0 4'h2
`define SRC_LEVEL1 4'h3
`define SRC_LEVEL2 4'h4
`define SRC_TMR0 4'h5
`define SRC_TMR1 4'h6
`define SRC_DMA0 4'h7
`define SRC_DMA1 4'h8
`define SRC_CSU 4'h9
`define SRC_SER0 4'hA
`define SRC_SER1 4'hB
`define SRC_NONE 4'hF
`define NUM_SRC 12

`endif

// ==== hw/pfn_pkg.sv ====
package pfn_pkg;
    typedef enum logic [1:0] {
        SUP_RUN = 2'b00,
        SUP_HOLDUP = 2'b01,
        SUP_RESET = 2'b10,
        SUP_DEAD = 2'b11
    } sup_state_t;
    typedef logic [3:0] src_id_t;
    typedef logic [15:0] addr_t;
endpackage

// ==== hw/power_fail_nmi_and_vectors.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "pfn_regs.svh"
module power_fail_nmi_and_vectors #(
    parameter int NMI_LATENCY_CYCLES = `NMI_LATENCY_NS / `CLK_PERIOD_NS,
    parameter logic [15:0] STACK_TOP = 16'hFFFE,
    parameter logic [15:0] TRAP_ADDR = 16'h0000,
    parameter logic [15:0] LEVEL0_ADDR = 16'h0040
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic raw_low_in,
    input wire logic rail_low_in,
    input wire logic rail_dead_in,
    input wire logic nmi_ext_n_in,
    input wire logic din11_in,
    input wire logic din12_in,
    input wire logic attn_level1_n_in,
    input wire logic [6:0] periph_irq_in,
    input wire logic trap_in,
    input wire logic [7:0] vec_page_in,
    input wire logic take_in,
    input wire pfn_pkg::addr_t pc_in,
    input wire logic return_from_nonmaskable_in,
    input wire logic set_ie_in,
    input wire logic clr_ie_in,
    output logic sys_reset_out,
    output logic sram_ce_n_out,
    output logic power_fail_flag_out,
    output logic [7:0] status_byte_out,
    output logic int_enable_live_out,
    output logic int_enable_saved_out,
    output logic accept_out,
    output pfn_pkg::src_id_t accept_src_out,
    output pfn_pkg::addr_t vector_addr_out,
    output logic push_out,
    output pfn_pkg::addr_t push_addr_out,
    output pfn_pkg::addr_t push_data_out,
    output pfn_pkg::addr_t stack_ptr_out,
    output logic [7:0] nmi_nest_out,
    output logic nmi_late_out
);
    import pfn_pkg::*;

    localparam int NSYNC = 7;
    localparam logic [NSYNC-1:0] SYNC_IDLE = 7'h78;
    localparam logic [15:0] LATE_CNT = 16'(NMI_LATENCY_CYCLES);

    logic [NSYNC-1:0] async_vec;
    logic [NSYNC-1:0] sync_q;
    assign async_vec = {attn_level1_n_in, din12_in, din11_in, nmi_ext_n_in,
                        rail_dead_in, rail_low_in, raw_low_in};

    // Three stages; a change counts once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < NSYNC; g++)
        begin : g_sync
            logic s1, s2, s3;
            always_ff @(posedge mclk_in)
            begin
                if (rst_in)
                begin
                    s1 <= SYNC_IDLE[g];
                    s2 <= SYNC_IDLE[g];
                    s3 <= SYNC_IDLE[g];
                    sync_q[g] <= SYNC_IDLE[g];
                end
                else
                begin
                    s1 <= async_vec[g];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3)
                        sync_q[g] <= s3;
                end
            end
        end
    endgenerate

    logic raw_low, rail_low, rail_dead, nmi_ext_n, din11, din12, attn_n;
    assign {attn_n, din12, din11, nmi_ext_n, rail_dead, rail_low, raw_low} =
        sync_q;

    // Supervisor
    sup_state_t state, next_state;
    always_comb
    begin
        next_state = state;
        unique case (state)
            SUP_RUN:
                if (raw_low)
                    next_state = SUP_HOLDUP;
            SUP_HOLDUP:
                if (rail_low)
                    next_state = SUP_RESET;
                else if (!raw_low)
                    next_state = SUP_RUN;
            SUP_RESET:
                if (rail_dead)
                    next_state = SUP_DEAD;
                else if (!rail_low && !raw_low)
                    next_state = SUP_RUN;
            SUP_DEAD:
                next_state = SUP_DEAD;
        endcase
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            state <= SUP_RUN;
        else
            state <= next_state;
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            sys_reset_out <= 1'b0;
            sram_ce_n_out <= 1'b0;
        end
        else
        begin
            sys_reset_out <= next_state[1];
            sram_ce_n_out <= next_state[1];
        end
    end

    // Detector status, frozen once the supervisor has stopped
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            power_fail_flag_out <= 1'b0;
            status_byte_out <= 8'h00;
        end
        else if (state != SUP_DEAD)
        begin
            power_fail_flag_out <= raw_low;
            status_byte_out <= 8'h00;
            status_byte_out[`PF_STATUS_BIT] <= raw_low;
        end
    end

    // Falling edge on the combined active-low NMI line
    logic nmi_line_n, nmi_prev_n, nmi_fall, nmi_pend, trap_pend;
    assign nmi_line_n = !power_fail_flag_out && nmi_ext_n;
    assign nmi_fall = nmi_prev_n && !nmi_line_n;

    logic [`NUM_SRC-1:0] req;
    src_id_t win;
    logic take_now;
    always_comb
    begin
        req = '0;
        req[`SRC_TRAP] = trap_pend;
        req[`SRC_NMI] = nmi_pend;
        req[`SRC_LEVEL0] = int_enable_live_out && !din11;
        req[`SRC_LEVEL1] = int_enable_live_out && !attn_n;
        req[`SRC_LEVEL2] = int_enable_live_out && !din12;
        req[`NUM_SRC-1:`SRC_TMR0] = int_enable_live_out ? periph_irq_in : '0;
        win = `SRC_NONE;
        for (int i = `NUM_SRC - 1; i >= 0; i--)
            if (req[i])
                win = 4'(i);
    end
    assign take_now = take_in && !sys_reset_out && (win != `SRC_NONE);

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            nmi_prev_n <= 1'b1;
            nmi_pend <= 1'b0;
            trap_pend <= 1'b0;
        end
        else
        begin
            nmi_prev_n <= nmi_line_n;
            if (nmi_fall)
                nmi_pend <= 1'b1;
            else if (take_now && win == `SRC_NMI)
                nmi_pend <= 1'b0;
            if (trap_in)
                trap_pend <= 1'b1;
            else if (take_now && win == `SRC_TRAP)
                trap_pend <= 1'b0;
        end
    end

    function automatic logic [7:0] vec_off(input src_id_t s);
        unique case (s)
            `SRC_LEVEL1: vec_off = `VEC_LEVEL1;
            `SRC_LEVEL2: vec_off = `VEC_LEVEL2;
            `SRC_TMR0: vec_off = `VEC_TMR0;
            `SRC_TMR1: vec_off = `VEC_TMR1;
            `SRC_DMA0: vec_off = `VEC_DMA0;
            `SRC_DMA1: vec_off = `VEC_DMA1;
            `SRC_CSU: vec_off = `VEC_CSU;
            `SRC_SER0: vec_off = `VEC_SER0;
            default: vec_off = `VEC_SER1;
        endcase
    endfunction

    // Acceptance: vector, push and enable flags
    always_ff @(posedge mclk_in)
    begin
        if (rst_in || sys_reset_out)
        begin
            accept_out <= 1'b0;
            accept_src_out <= `SRC_NONE;
            vector_addr_out <= 16'h0000;
            push_out <= 1'b0;
            push_addr_out <= 16'h0000;
            push_data_out <= 16'h0000;
            stack_ptr_out <= STACK_TOP;
            int_enable_live_out <= 1'b0;
            int_enable_saved_out <= 1'b0;
            nmi_nest_out <= 8'h00;
        end
        else
        begin
            accept_out <= take_now;
            push_out <= take_now;
            if (take_now)
            begin
                accept_src_out <= win;
                push_addr_out <= stack_ptr_out - `PC_BYTES;
                push_data_out <= pc_in;
                stack_ptr_out <= stack_ptr_out - `PC_BYTES;
                if (win == `SRC_TRAP)
                    vector_addr_out <= TRAP_ADDR;
                else if (win == `SRC_NMI)
                    vector_addr_out <= `NMI_JUMP_ADDR;
                else if (win == `SRC_LEVEL0)
                    vector_addr_out <= LEVEL0_ADDR;
                else
                    vector_addr_out <= {vec_page_in, vec_off(win)};
                if (win == `SRC_NMI)
                begin
                    int_enable_saved_out <= int_enable_live_out;
                    nmi_nest_out <= nmi_nest_out + 8'h01;
                end
                int_enable_live_out <= 1'b0;
            end
            else if (return_from_nonmaskable_in)
            begin
                int_enable_live_out <= int_enable_saved_out;
                stack_ptr_out <= stack_ptr_out + `PC_BYTES;
                if (nmi_nest_out != 8'h00)
                    nmi_nest_out <= nmi_nest_out - 8'h01;
            end
            else if (set_ie_in)
                int_enable_live_out <= 1'b1;
            else if (clr_ie_in)
                int_enable_live_out <= 1'b0;
        end
    end

    // Flags an NMI left pending longer than the entry budget
    logic [15:0] late_cnt;
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            late_cnt <= 16'h0000;
            nmi_late_out <= 1'b0;
        end
        else if (!nmi_pend || nmi_fall)
            late_cnt <= 16'h0000;
        else if (late_cnt == LATE_CNT - 16'h0001)
            nmi_late_out <= 1'b1;
        else
            late_cnt <= late_cnt + 16'h0001;
    end

    pf_nmi_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        $rose(power_fail_flag_out) && $past(nmi_line_n) |=> nmi_pend)
        else $error("power fail did not raise nmi");
    reset_entry_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        state == SUP_HOLDUP && rail_low |=> state == SUP_RESET ##1 sys_reset_out)
        else $error("reset not asserted after rail drop");
    sram_standby_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        sys_reset_out |-> sram_ce_n_out)
        else $error("sram not in standby during reset");
    reset_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        state == SUP_DEAD |=> sys_reset_out [*3])
        else $error("reset released after supervisor stopped");
    nmi_push_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        take_now && win == `SRC_NMI |=> push_out && push_data_out == $past(pc_in)
        && push_addr_out == $past(stack_ptr_out) - `PC_BYTES)
        else $error("pc not pushed on nmi");
    ief_copy_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        take_now && win == `SRC_NMI |=> !int_enable_live_out
        && int_enable_saved_out == $past(int_enable_live_out))
        else $error("enable flags not moved on nmi");
    return_from_nonmaskable_restore_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        return_from_nonmaskable_in && !take_now && !sys_reset_out
        |=> int_enable_live_out == $past(int_enable_saved_out))
        else $error("return did not restore enable");
    nmi_nest_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        take_now && win == `SRC_NMI && !sys_reset_out
        |=> nmi_nest_out == $past(nmi_nest_out) + 8'h01)
        else $error("nest count wrong");
    nmi_edge_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        !nmi_pend && !nmi_fall |=> !nmi_pend)
        else $error("nmi raised without falling edge");
    vector_page_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        take_now && win == `SRC_TMR0 && !sys_reset_out
        |=> vector_addr_out == {$past(vec_page_in), `VEC_TMR0})
        else $error("vector address wrong");
    priority_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        take_now && nmi_pend && !trap_pend && !sys_reset_out
        |=> accept_src_out == `SRC_NMI)
        else $error("nmi lost priority");
    status_bit_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        state != SUP_DEAD |=> status_byte_out[`PF_STATUS_BIT] == $past(raw_low))
        else $error("status bit does not follow detector");
endmodule
`default_nettype wire

// ==== verification/supply_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module supply_model (
    input wire logic mclk_in,
    input wire logic [1:0] stage_in,
    output logic raw_low_out,
    output logic rail_low_out,
    output logic rail_dead_out
);
    initial
    begin
        raw_low_out = 1'b0;
        rail_low_out = 1'b0;
        rail_dead_out = 1'b0;
    end
    // Decay is monotonic: each lower threshold implies those above it
    always @(posedge mclk_in)
    begin
        raw_low_out <= #1 stage_in != 2'h0;
        rail_low_out <= #1 stage_in >= 2'h2;
        rail_dead_out <= #1 stage_in == 2'h3;
    end
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import pfn_pkg::*;
    localparam int LAT = 20;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [1:0] stage = 2'h0;
    logic raw_low, rail_low, rail_dead;
    logic nmi_n = 1'b1, din11 = 1'b1, din12 = 1'b1, attn_n = 1'b1;
    logic [6:0] pirq = 7'h00;
    logic trap = 1'b0, take = 1'b0, return_from_nonmaskable = 1'b0, set_ie = 1'b0;
    logic [7:0] page = 8'hA5;
    addr_t pc = 16'h1234;
    addr_t exp_sp = 16'hFFFE;
    logic sys_reset, sram_ce_n, pf_flag, live, saved, accept, push, late;
    logic [7:0] status, nest;
    src_id_t src;
    addr_t vec, push_addr, push_data, sp;
    int miscompares = 0;
    int tests_run = 0;

    supply_model supply (.mclk_in(mclk_in), .stage_in(stage),
        .raw_low_out(raw_low), .rail_low_out(rail_low),
        .rail_dead_out(rail_dead));

    power_fail_nmi_and_vectors #(.NMI_LATENCY_CYCLES(LAT)) DUT (
        .mclk_in(mclk_in), .rst_in(rst_in), .raw_low_in(raw_low),
        .rail_low_in(rail_low), .rail_dead_in(rail_dead),
        .nmi_ext_n_in(nmi_n), .din11_in(din11), .din12_in(din12),
        .attn_level1_n_in(attn_n), .periph_irq_in(pirq), .trap_in(trap),
        .vec_page_in(page), .take_in(take), .pc_in(pc),
        .return_from_nonmaskable_in(return_from_nonmaskable), .set_ie_in(set_ie),
        .clr_ie_in(1'b0), .sys_reset_out(sys_reset),
        .sram_ce_n_out(sram_ce_n), .power_fail_flag_out(pf_flag),
        .status_byte_out(status), .int_enable_live_out(live),
        .int_enable_saved_out(saved), .accept_out(accept),
        .accept_src_out(src), .vector_addr_out(vec), .push_out(push),
        .push_addr_out(push_addr), .push_data_out(push_data),
        .stack_ptr_out(sp), .nmi_nest_out(nest), .nmi_late_out(late));

    initial
        forever #5 mclk_in = ~mclk_in;

    task automatic tally_and_finish;
        $display("compares=%0d mismatches=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk_word(input addr_t got, input addr_t exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask

    task automatic pulse_ie;
        set_ie = 1'b1;
        cyc(1);
        set_ie = 1'b0;
    endtask

    task automatic pulse_return_from_nonmaskable;
        return_from_nonmaskable = 1'b1;
        cyc(1);
        return_from_nonmaskable = 1'b0;
        cyc(1);
    endtask

    // Hold take until one acceptance shows, then judge source and vector
    task automatic take_one(input src_id_t s, input addr_t v);
        int i;
        logic ok;
        ok = 1'b0;
        take = 1'b1;
        for (i = 0; i < 12 && !ok; i++)
        begin
            cyc(1);
            ok = (accept === 1'b1);
        end
        take = 1'b0;
        chk_bit(ok, 1'b1);
        chk_word({12'h000, src}, {12'h000, s});
        chk_word(vec, v);
    endtask

    task automatic nmi_take;
        take_one(4'h1, 16'h0066);
        chk_bit(push, 1'b1);
        chk_word(push_addr, exp_sp - 16'h0002);
        chk_word(push_data, pc);
        exp_sp = exp_sp - 16'h0002;
        pc = pc + 16'h0010;
    endtask

    task automatic test_nmi_entry;
        pulse_ie();
        stage = 2'h1;
        nmi_take();
        chk_bit(live, 1'b0);
        chk_bit(saved, 1'b1);
        chk_word({8'h00, nest}, 16'h0001);
        chk_bit(pf_flag, 1'b1);
        chk_word({8'h00, status}, 16'h0008);
        chk_bit(late, 1'b0);
        $display("test_nmi_entry done");
    endtask

    task automatic test_edge_only;
        int hits;
        hits = 0;
        take = 1'b1;
        repeat (30)
        begin
            cyc(1);
            hits += (accept !== 1'b0);
        end
        take = 1'b0;
        chk_word(16'(hits), 16'h0000);
        pulse_return_from_nonmaskable();
        exp_sp = exp_sp + 16'h0002;
        chk_bit(live, 1'b1);
        chk_word(sp, exp_sp);
        stage = 2'h0;
        cyc(8);
        chk_word({8'h00, status}, 16'h0000);
        $display("test_edge_only done");
    endtask

    task automatic test_nested;
        nmi_n = 1'b0;
        nmi_take();
        chk_bit(saved, 1'b1);
        nmi_n = 1'b1;
        cyc(8);
        nmi_n = 1'b0;
        nmi_take();
        chk_bit(saved, 1'b0);
        chk_word({8'h00, nest}, 16'h0002);
        chk_word(sp, exp_sp);
        nmi_n = 1'b1;
        pulse_return_from_nonmaskable();
        chk_bit(live, 1'b0);
        pulse_return_from_nonmaskable();
        exp_sp = exp_sp + 16'h0004;
        chk_word(sp, exp_sp);
        $display("test_nested done");
    endtask

    task automatic test_vectors;
        int i;
        trap = 1'b1;
        cyc(1);
        trap = 1'b0;
        nmi_n = 1'b0;
        cyc(6);
        take_one(4'h0, 16'h0000);
        exp_sp = exp_sp - 16'h0002;
        nmi_take();
        nmi_n = 1'b1;
        {din11, din12, attn_n, pirq} = {3'b000, 7'h7F};
        cyc(6);
        pulse_ie();
        take_one(4'h2, 16'h0040);
        din11 = 1'b1;
        cyc(6);
        pulse_ie();
        take_one(4'h3, {page, 8'h00});
        attn_n = 1'b1;
        cyc(6);
        pulse_ie();
        take_one(4'h4, {page, 8'h02});
        din12 = 1'b1;
        cyc(6);
        for (i = 0; i < 7; i++)
        begin
            pulse_ie();
            take_one(4'(5 + i), {page, 8'(4 + 2 * i)});
            pirq[i] = 1'b0;
            cyc(1);
        end
        $display("test_vectors done");
    endtask

    task automatic test_power_down;
        stage = 2'h1;
        cyc(10);
        chk_bit(sys_reset, 1'b0);
        stage = 2'h2;
        cyc(10);
        chk_bit(sys_reset, 1'b1);
        chk_bit(sram_ce_n, 1'b1);
        stage = 2'h3;
        cyc(10);
        chk_bit(sys_reset, 1'b1);
        chk_bit(sram_ce_n, 1'b1);
        chk_bit(late, 1'b1);
        $display("test_power_down done");
    endtask

    initial
    begin
        #100000;
        miscompares++;
        tally_and_finish();
    end

    initial
    begin
        cyc(6);
        rst_in = 1'b0;
        cyc(4);
        test_nmi_entry();
        test_edge_only();
        test_nested();
        test_vectors();
        test_power_down();
        tally_and_finish();
    end
endmodule
`default_nettype wire
